// ### core/afs_pkg.sv
// Package for the frame sync pin block: register map, fields, modes.
// Assumes a word-indexed register port with 8-bit data.
`default_nettype none
package afs_pkg;
  // ==========================================
  // Register indexes
  localparam logic [2:0] AFS_RCC_IDX  = 3'h0; // receive_clock_control_reg
  localparam logic [2:0] AFS_TCC_IDX  = 3'h1; // transmit_clock_control_reg
  localparam logic [2:0] AFS_CCR_IDX  = 3'h2; // common_control_reg
  localparam logic [2:0] AFS_CSR_IDX  = 3'h3; // common_status_reg
  localparam logic [2:0] AFS_PMD_IDX  = 3'h4; // Port pin modes
  localparam logic [2:0] AFS_PDT_IDX  = 3'h5; // Port pin data
  // ==========================================
  // Field positions
  localparam int AFS_RX_FRAME_SYNC_DIRECTION_BIT = 0; // rx_frame_sync_direction
  localparam int AFS_TX_FRAME_SYNC_DIRECTION_BIT = 0; // tx_frame_sync_direction
  localparam int AFS_SYN_BIT  = 0; // sync_mode_select
  localparam int AFS_TX_BUFFER_ENABLE_SELECT_BIT = 1; // tx_buffer_enable_select
  localparam int AFS_OF1_BIT  = 2; // output_flag_one
  localparam int AFS_NET_BIT  = 3; // Network mode
  localparam int AFS_IF1_BIT  = 0; // input_flag_one
  localparam int AFS_PM_RX    = 0; // Mode field of port_pin_one
  localparam int AFS_PM_TX    = 2; // Mode field of port_pin_four
  // ==========================================
  // Reset values
  localparam logic [7:0] AFS_RCC_RST = 8'h00;
  localparam logic [7:0] AFS_TCC_RST = 8'h00;
  localparam logic [7:0] AFS_CCR_RST = 8'h00;
  localparam logic [3:0] AFS_PMD_RST = 4'h0;
  localparam logic [1:0] AFS_PDT_RST = 2'h0;
  // ==========================================
  // Per-pin mode
  typedef enum logic [1:0] {
    AFS_PIN_OFF    = 2'b00, // Disconnected
    AFS_PIN_GPI    = 2'b01, // General-purpose input
    AFS_PIN_GPO    = 2'b10, // General-purpose output
    AFS_PIN_SERIAL = 2'b11  // Serial port function
  } afs_pin_mode_t;
  // ==========================================
  // Whole module state
  typedef struct packed {
    logic [3:0] sync1;     // First synchroniser stage
    logic [3:0] sync2;     // Second synchroniser stage
    logic       tck_prev;
    logic       rck_prev;
    logic       tfs_smp;   // Tx frame sync sampled on bit clock
    logic       rfs_smp;   // Rx frame sync sampled on bit clock
    logic       tfs_prev;
    logic [7:0] rcc_reg;
    logic [7:0] tcc_reg;
    logic [7:0] ccr_reg;
    logic [3:0] pmd_reg;
    logic [1:0] pdt_reg;
    logic       flag_out;  // Output flag as shown on the pin
    logic       if1;
    logic [7:0] rdata;
    logic       rfs_o;
    logic       rfs_oe_b;
    logic       tfs_o;
    logic       tfs_oe_b;
    logic       tx_fs;
    logic       rx_fs;
    logic       tx_bclk_en;
    logic       rx_bclk_en;
  } afs_state_t;
endpackage
`default_nettype wire

// ### core/afs_frame_sync_pins.sv
// Frame sync pins of the second serial audio port, with flags and GPIO.
// Assumes bit clocks and pins are asynchronous; frame sync generators,
// slot strobe and transmitter activity come from logic on i_sys_clk.
//
// Summary of operation
// - Async: receive pin is the receivers' own frame sync
// - Sync, buffer select clear: receive pin is flag
// - Sync, buffer select and direction: buffer enable
// - Flag direction from rx direction bit
// - Output flag shows output_flag_one
// - Flag changes at frame sync or slot
// - Input flag captured at frame sync or slot
// - Sync: transmit pin is the common frame sync
// - Async: transmit pin serves transmitters only
// - Transmit pin direction from tx direction bit
// - GPIO: each pin input, output or disconnected
// - After reset every pin disconnected
// - Transmit bit clock drives both sides in sync
`timescale 1ns/1ps
`default_nettype none
module afs_frame_sync_pins
  import afs_pkg::*;
(
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_b,
  // Register port
  input  wire logic [2:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  output logic      [7:0] o_reg_rdata,
  // Bit clock pins, sampled
  input  wire logic       i_tx_bclk_pin,
  input  wire logic       i_rx_bclk_pin,
  // Receive frame sync pin
  input  wire logic       i_rx_fs_pin,
  output logic            o_rx_fs_pin,
  output logic            o_rx_fs_pin_oe_b,
  // Transmit frame sync pin
  input  wire logic       i_tx_fs_pin,
  output logic            o_tx_fs_pin,
  output logic            o_tx_fs_pin_oe_b,
  // Internal serial logic
  input  wire logic       i_tx_fs_gen,
  input  wire logic       i_rx_fs_gen,
  input  wire logic       i_slot_start,
  input  wire logic       i_tx_active,
  output logic            o_tx_fs,
  output logic            o_rx_fs,
  output logic            o_tx_bclk_en,
  output logic            o_rx_bclk_en
);
  import afs_pkg::*;

  afs_state_t st_reg;
  afs_state_t st_next;

  // ==========================================
  // Decoded controls
  logic          syn;
  logic          tx_buffer_enable_select;
  logic          net;
  logic          rx_frame_sync_direction;
  logic          tx_frame_sync_direction;
  afs_pin_mode_t rx_md;
  afs_pin_mode_t tx_md;
  logic          s_tck;
  logic          s_rck;
  logic          s_tfs;
  logic          s_rfs;
  logic          tck_rise;
  logic          rck_rise;
  logic          tx_fs_eff;
  logic          rx_fs_eff;
  logic          flag_evt;
  logic          rx_is_flag;

  // Control fields from registers
  assign syn   = st_reg.ccr_reg[AFS_SYN_BIT];
  assign tx_buffer_enable_select  = st_reg.ccr_reg[AFS_TX_BUFFER_ENABLE_SELECT_BIT];
  assign net   = st_reg.ccr_reg[AFS_NET_BIT];
  assign rx_frame_sync_direction  = st_reg.rcc_reg[AFS_RX_FRAME_SYNC_DIRECTION_BIT];
  assign tx_frame_sync_direction  = st_reg.tcc_reg[AFS_TX_FRAME_SYNC_DIRECTION_BIT];
  assign rx_md = afs_pin_mode_t'(st_reg.pmd_reg[AFS_PM_RX +: 2]);
  assign tx_md = afs_pin_mode_t'(st_reg.pmd_reg[AFS_PM_TX +: 2]);

  // Synchronised pin levels: {rx fs, tx fs, rx bclk, tx bclk}
  assign s_tck = st_reg.sync2[0];
  assign s_rck = st_reg.sync2[1];
  assign s_tfs = st_reg.sync2[2];
  assign s_rfs = st_reg.sync2[3];

  // Bit clock rising edges
  assign tck_rise = s_tck & ~st_reg.tck_prev;
  assign rck_rise = s_rck & ~st_reg.rck_prev;

  // Effective frame syncs
  assign tx_fs_eff  = tx_frame_sync_direction ? i_tx_fs_gen : st_reg.tfs_smp;
  assign rx_fs_eff  = syn ? tx_fs_eff
                    : (rx_frame_sync_direction ? i_rx_fs_gen : st_reg.rfs_smp);
  assign rx_is_flag = syn & ~tx_buffer_enable_select;

  // Flag timing: frame sync edge, or slot in network mode
  assign flag_evt = net ? i_slot_start
                  : (tx_fs_eff & ~st_reg.tfs_prev);

  // ==========================================
  // Next state
  always_comb begin
    st_next = st_reg;

    // Two-stage synchronisers
    st_next.sync1    = {i_rx_fs_pin, i_tx_fs_pin, i_rx_bclk_pin, i_tx_bclk_pin};
    st_next.sync2    = st_reg.sync1;
    st_next.tck_prev = s_tck;
    st_next.rck_prev = s_rck;
    st_next.tfs_prev = tx_fs_eff;

    // Input frame syncs sampled on their own bit clock, rx on the tx bit clock when syn
    if (tck_rise) begin
      st_next.tfs_smp = s_tfs;
    end
    if (syn ? tck_rise : rck_rise) begin
      st_next.rfs_smp = s_rfs;
    end

    // Bit clock enables for both sides
    st_next.tx_bclk_en = tck_rise;
    st_next.rx_bclk_en = syn ? tck_rise : rck_rise;
    st_next.tx_fs      = tx_fs_eff;
    st_next.rx_fs      = rx_fs_eff;

    // Flags synchronised to frame or slot
    if (flag_evt) begin
      st_next.flag_out = st_reg.ccr_reg[AFS_OF1_BIT];
      if (rx_is_flag && !rx_frame_sync_direction && rx_md == AFS_PIN_SERIAL) begin
        st_next.if1 = s_rfs;
      end
    end

    // Receive frame sync pin drive
    st_next.rfs_o    = 1'b0;
    st_next.rfs_oe_b = 1'b1;
    case (rx_md)
      AFS_PIN_SERIAL: begin
        if (!syn) begin
          st_next.rfs_o    = i_rx_fs_gen;
          st_next.rfs_oe_b = ~rx_frame_sync_direction;
        end else if (!tx_buffer_enable_select) begin
          st_next.rfs_o    = st_reg.flag_out;
          st_next.rfs_oe_b = ~rx_frame_sync_direction;
        end else if (rx_frame_sync_direction) begin
          st_next.rfs_o    = i_tx_active;
          st_next.rfs_oe_b = 1'b0;
        end
      end
      AFS_PIN_GPO: begin
        st_next.rfs_o    = st_reg.pdt_reg[0];
        st_next.rfs_oe_b = 1'b0;
      end
      default: begin
        st_next.rfs_oe_b = 1'b1;
      end
    endcase

    // Transmit frame sync pin drive
    st_next.tfs_o    = 1'b0;
    st_next.tfs_oe_b = 1'b1;
    case (tx_md)
      AFS_PIN_SERIAL: begin
        st_next.tfs_o    = i_tx_fs_gen;
        st_next.tfs_oe_b = ~tx_frame_sync_direction;
      end
      AFS_PIN_GPO: begin
        st_next.tfs_o    = st_reg.pdt_reg[1];
        st_next.tfs_oe_b = 1'b0;
      end
      default: begin
        st_next.tfs_oe_b = 1'b1;
      end
    endcase

    // Register writes
    if (i_reg_wr) begin
      if (i_reg_addr == AFS_RCC_IDX) begin
        st_next.rcc_reg = i_reg_wdata;
      end else if (i_reg_addr == AFS_TCC_IDX) begin
        st_next.tcc_reg = i_reg_wdata;
      end else if (i_reg_addr == AFS_CCR_IDX) begin
        st_next.ccr_reg = i_reg_wdata;
      end else if (i_reg_addr == AFS_PMD_IDX) begin
        st_next.pmd_reg = i_reg_wdata[3:0];
      end else if (i_reg_addr == AFS_PDT_IDX) begin
        st_next.pdt_reg = i_reg_wdata[1:0];
      end
    end

    // Register reads, data one cycle later
    st_next.rdata = 8'h00;
    if (i_reg_rd) begin
      if (i_reg_addr == AFS_RCC_IDX) begin
        st_next.rdata = st_reg.rcc_reg;
      end else if (i_reg_addr == AFS_TCC_IDX) begin
        st_next.rdata = st_reg.tcc_reg;
      end else if (i_reg_addr == AFS_CCR_IDX) begin
        st_next.rdata = st_reg.ccr_reg;
      end else if (i_reg_addr == AFS_CSR_IDX) begin
        st_next.rdata[AFS_IF1_BIT] = st_reg.if1;
      end else if (i_reg_addr == AFS_PMD_IDX) begin
        st_next.rdata = {4'h0, st_reg.pmd_reg};
      end else if (i_reg_addr == AFS_PDT_IDX) begin
        // Disconnected pins read as zero
        st_next.rdata = {6'h00,
                         (tx_md == AFS_PIN_GPI) & s_tfs,
                         (rx_md == AFS_PIN_GPI) & s_rfs};
      end
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_reg          <= '0;
      st_reg.rcc_reg  <= AFS_RCC_RST;
      st_reg.tcc_reg  <= AFS_TCC_RST;
      st_reg.ccr_reg  <= AFS_CCR_RST;
      st_reg.pmd_reg  <= AFS_PMD_RST;
      st_reg.pdt_reg  <= AFS_PDT_RST;
      st_reg.rfs_oe_b <= 1'b1;
      st_reg.tfs_oe_b <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================
  // Outputs
  assign o_reg_rdata      = st_reg.rdata;
  assign o_rx_fs_pin      = st_reg.rfs_o;
  assign o_rx_fs_pin_oe_b = st_reg.rfs_oe_b;
  assign o_tx_fs_pin      = st_reg.tfs_o;
  assign o_tx_fs_pin_oe_b = st_reg.tfs_oe_b;
  assign o_tx_fs          = st_reg.tx_fs;
  assign o_rx_fs          = st_reg.rx_fs;
  assign o_tx_bclk_en     = st_reg.tx_bclk_en;
  assign o_rx_bclk_en     = st_reg.rx_bclk_en;

endmodule // afs_frame_sync_pins
`default_nettype wire

// ### testbench/afs_codec_model.sv
// Far-side codec: bit clock and frame sync for one pin.
// Assumes the bench resolves the pin against the device drive.
`timescale 1ns/1ps
`default_nettype none
module afs_codec_model (
  input  wire logic i_run,
  input  wire logic i_fs,
  output logic      o_bclk,
  output logic      o_fs
);
  // 160 ns bit clock, still between frames; sync moves on low phase
  initial begin
    o_bclk = 1'b0;
    o_fs   = 1'b0;
    forever begin
      #80;
      o_bclk = i_run ? ~o_bclk : 1'b0;
      if (!o_bclk) o_fs = i_fs;
    end
  end
endmodule // afs_codec_model
`default_nettype wire

// ### testbench/afs_frame_sync_pins_chk.sv
// Checker: port timing of the frame sync pin block.
// Assumes binding to afs_frame_sync_pins.
`timescale 1ns/1ps
`default_nettype none
module afs_chk (
  input wire logic       i_sys_clk,
  input wire logic       i_rst_b,
  input wire logic [2:0] i_reg_addr,
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic       i_tx_bclk_pin,
  input wire logic       o_tx_bclk_en,
  input wire logic       o_rx_bclk_en,
  input wire logic       o_rx_fs_pin_oe_b,
  input wire logic       o_tx_fs_pin_oe_b
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  // ==========================================
  // Register port and pin state
  sequence s_bad_read;
    $past(i_reg_rd) && $past(i_reg_addr) > 3'h5;
  endsequence
  a_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  a_rd_unmapped: assert property (s_bad_read |-> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_oe_reset: assert property ($rose(i_rst_b) |-> o_rx_fs_pin_oe_b && o_tx_fs_pin_oe_b)
    else $error("pin driven after reset");
  a_rx_oe_cfg: assert property ($changed(o_rx_fs_pin_oe_b) |-> $past(i_reg_wr, 2))
    else $error("rx pin direction moved without write");
  a_tx_oe_cfg: assert property ($changed(o_tx_fs_pin_oe_b) |-> $past(i_reg_wr, 2))
    else $error("tx pin direction moved without write");
  // ==========================================
  // Bit clock edge pulses
  a_txen_pulse: assert property (o_tx_bclk_en |=> !o_tx_bclk_en)
    else $error("tx bit clock pulse too long");
  a_rxen_pulse: assert property (o_rx_bclk_en |=> !o_rx_bclk_en)
    else $error("rx bit clock pulse too long");
  a_txen_cause: assert property (o_tx_bclk_en |->
    $past(i_tx_bclk_pin, 3) && !$past(i_tx_bclk_pin, 4))
    else $error("tx pulse without bit clock rise");
endmodule // afs_chk
`default_nettype wire

// ### testbench/afs_frame_sync_pins_tb.sv
// Bench: register port, pin modes, flags, frame sync routing.
// Assumes two codec models on the frame sync pins.
`timescale 1ns/1ps
`default_nettype none
module afs_frame_sync_pins_tb;
  import afs_pkg::*;
  logic i_sys_clk = 1'b0, i_rst_b = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic [2:0] i_reg_addr = 3'h0;
  logic [7:0] i_reg_wdata = 8'h00, o_reg_rdata;
  logic i_tx_fs_gen = 1'b0, i_rx_fs_gen = 1'b0, i_slot_start = 1'b0, i_tx_active = 1'b0;
  logic tx_run = 1'b0, rx_run = 1'b0, tx_lvl = 1'b0, rx_lvl = 1'b0, tx_far, rx_far;
  logic i_tx_bclk_pin, i_rx_bclk_pin, o_rx_fs_pin, o_tx_fs_pin, o_tx_fs, o_rx_fs;
  logic o_rx_fs_pin_oe_b, o_tx_fs_pin_oe_b, o_tx_bclk_en, o_rx_bclk_en;
  wire logic i_rx_fs_pin = o_rx_fs_pin_oe_b ? rx_far : o_rx_fs_pin;
  wire logic i_tx_fs_pin = o_tx_fs_pin_oe_b ? tx_far : o_tx_fs_pin;
  int err_total = 0, n_checks = 0, seed = 32921, a, v, cfg[8];
  afs_codec_model u_tx (.i_run(tx_run), .i_fs(tx_lvl), .o_bclk(i_tx_bclk_pin), .o_fs(tx_far));
  afs_codec_model u_rx (.i_run(rx_run), .i_fs(rx_lvl), .o_bclk(i_rx_bclk_pin), .o_fs(rx_far));
  afs_frame_sync_pins DUT (.*);
  always #10 i_sys_clk = ~i_sys_clk;
  // Model: pin driven when GP output or serial with direction out
  function automatic bit drv(int dir, int pm);
    return (pm & 3) == 2 || ((pm & 3) == 3 && dir[0]);
  endfunction
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input int ad, input int vd);
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= ad[2:0];
    i_reg_wdata <= vd[7:0];
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b0;
    if (ad < 6 && ad != 3) cfg[ad] = vd;
    repeat (2) @(posedge i_sys_clk);
    #1;
    chk("rx oe", o_rx_fs_pin_oe_b, !drv(cfg[0], cfg[4]));
    chk("tx oe", o_tx_fs_pin_oe_b, !drv(cfg[1], cfg[4] >> 2));
  endtask
  task automatic rd(input int ad, input int e);
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= ad[2:0];
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b0;
    #1 chk("rdata", o_reg_rdata, e[7:0]);
  endtask
  task automatic wt(input bit sel);
    int k;
    for (k = 0; k < 40; k++) begin
      @(posedge i_sys_clk);
      #1;
      if (sel ? o_rx_bclk_en : o_tx_fs) break;
    end
    if (k == 40) begin
      err_total++;
      results;
    end
  endtask
  task automatic slot;
    @(posedge i_sys_clk) i_slot_start <= 1'b1;
    @(posedge i_sys_clk) i_slot_start <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    #1;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (5) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    for (int r = 0; r < 8; r++) rd(r, 0);
    repeat (12) begin
      a = $random(seed) & 3;
      a = (a == 2) ? 4 : (a == 3) ? 7 : a;
      wr(a, $random(seed) & 8'hff);
    end
    // GPIO: receive pin out, transmit pin in
    wr(4, 6);
    v = $random(seed) & 1;
    wr(5, v);
    chk("gpo", o_rx_fs_pin, v[0]);
    tx_lvl <= v[0];
    repeat (10) @(posedge i_sys_clk);
    rd(5, v << 1);
    // Async: both pins drive internal frame syncs
    wr(0, 1);
    wr(1, 1);
    wr(4, 8'hf);
    i_rx_fs_gen <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    #1 chk("fs out", {o_rx_fs_pin, o_tx_fs_pin}, 2'b10);
    wr(0, 0);
    wr(1, 0);
    {tx_run, rx_run, tx_lvl} <= 3'b111;
    wt(0);
    chk("rx fs async", o_rx_fs, 0);
    // Sync: transmit pin and bit clock serve receivers
    tx_lvl <= 1'b0;
    rx_run <= 1'b0;
    repeat (30) @(posedge i_sys_clk);
    wr(2, 1);
    tx_lvl <= 1'b1;
    wt(0);
    chk("rx fs sync", o_rx_fs, 1);
    wt(1);
    chk("rx bclk", o_rx_bclk_en, 1);
    // Flags in network mode, at the slot only
    {tx_run, rx_lvl} <= 2'b01;
    wr(2, 9);
    repeat (8) @(posedge i_sys_clk);
    rd(3, 0);
    slot;
    rd(3, 1);
    wr(0, 1);
    wr(2, 8'hd);
    chk("flag hold", o_rx_fs_pin, 0);
    slot;
    chk("flag", o_rx_fs_pin, 1);
    // Normal mode: flag moves only at a rising transmit frame sync
    wr(2, 1);
    tx_lvl <= 1'b0;
    tx_run <= 1'b1;
    repeat (30) @(posedge i_sys_clk);
    #1 chk("flag normal hold", o_rx_fs_pin, 1);
    tx_lvl <= 1'b1;
    wt(0);
    repeat (2) @(posedge i_sys_clk);
    #1 chk("flag normal", o_rx_fs_pin, 0);
    // Buffer enable follows transmitter activity
    wr(2, 3);
    repeat (4) begin
      @(posedge i_sys_clk) i_tx_active <= $random(seed);
      repeat (3) @(posedge i_sys_clk);
      #1 chk("buf", o_rx_fs_pin, i_tx_active);
    end
    results;
  end
endmodule // afs_frame_sync_pins_tb
bind afs_frame_sync_pins afs_chk u_chk (.*);
`default_nettype wire
